//--- logic/channel_alarm_flags.sv
`timescale 1ns/1ps
module channel_alarm_flags
    import alarm_flag_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // device variant strap, high for the four-channel part
    input wire logic four_chan,
    // conversion results from the threshold comparators
    input wire conv_t conv,
    // register read request from the serial port
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    output logic rd_busy,
    // serial data out, one shift per enable pulse
    input wire logic sclk_shift,
    output logic sdo,
    // flag state for the overview and alarm pin logic
    output logic [15:0] live_flags,
    output logic [15:0] latched_flags
);

    // ************************************************************
    // helpers
    // ************************************************************

    // bit position of a channel flag: bank from chan[2], pairs low then high
    function automatic logic [3:0] flag_index(input logic [2:0] chan, input logic high);
        logic [2:0] pos;
        pos = 3'(FLAG_TOP - 3'({chan[1:0], 1'b0}) - 3'({2'h0, high}));
        return {chan[2], pos};
    endfunction

    // address decode, shared by the read path and the checks
    function automatic reg_sel_t decode_addr(input logic [6:0] addr);
        unique case (addr)
            ADDR_LATCHED_LO: return SEL_LATCHED_LO;
            ADDR_LIVE_LO: return SEL_LIVE_LO;
            ADDR_LATCHED_HI: return SEL_LATCHED_HI;
            ADDR_LIVE_HI: return SEL_LIVE_HI;
            default: return SEL_NONE;
        endcase
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    flag_state_t st_q;
    flag_state_t st_d;
    reg_sel_t sel;
    logic rd_take;
    logic [7:0] load_byte;
    logic [7:0] load_mask;
    logic load_bank;
    logic sh_busy;
    logic sh_done;
    logic conv_ok;
    logic [3:0] idx_lo;
    logic [3:0] idx_hi;
    logic [15:0] latched_now;

    assign sel = decode_addr(reg_addr);
    // a read is refused while a byte is still shifting
    assign rd_take = reg_rd && !sh_busy && (sel != SEL_NONE);
    assign idx_lo = flag_index(conv.chan, 1'b0);
    assign idx_hi = flag_index(conv.chan, 1'b1);
    // ch4-7 results are dropped on the four-channel part
    assign conv_ok = conv.valid && !(four_chan && conv.chan[2]);

    // latched view after any clear due this cycle, so a read taken right
    // behind the previous byte never reports bits that byte already spent
    always_comb begin
        latched_now = st_q.latched;
        if (sh_done) begin
            if (st_q.clr_bank) begin
                latched_now[15:8] = st_q.latched[15:8] & ~st_q.clr_mask;
            end else begin
                latched_now[7:0] = st_q.latched[7:0] & ~st_q.clr_mask;
            end
        end
    end

    // ************************************************************
    // read byte select
    // ************************************************************

    // a latched read's clear mask is the byte it reports (none for live or absent-bank reads), so late sets survive the clear
    always_comb begin
        load_byte = FLAGS_RESET;
        load_mask = NO_CLEAR;
        load_bank = 1'b0;
        unique case (sel)
            SEL_LATCHED_LO: begin
                // full byte of latched ch0-3 flags
                load_byte = latched_now[7:0];
                load_mask = latched_now[7:0];
            end
            SEL_LIVE_LO: begin
                load_byte = st_q.live[7:0];
            end
            SEL_LATCHED_HI: begin
                load_bank = 1'b1;
                if (four_chan) begin
                    load_byte = ABSENT_READ;
                end else begin
                    load_byte = latched_now[15:8];
                    load_mask = latched_now[15:8];
                end
            end
            SEL_LIVE_HI: begin
                load_byte = four_chan ? ABSENT_READ : st_q.live[15:8];
            end
            SEL_NONE: begin
                load_byte = FLAGS_RESET;
            end
        endcase
    end

    // ************************************************************
    // flag update
    // ************************************************************

    // flags change only by conversions and read clears, no write path
    always_comb begin
        st_d = st_q;
        // clear reported bits once the byte has fully shifted out
        st_d.latched = latched_now;
        if (sh_done) begin
            st_d.clr_mask = NO_CLEAR;
        end
        // a read taken in the clear cycle arms its mask after the old one is spent
        if (rd_take) begin
            st_d.clr_bank = load_bank;
            st_d.clr_mask = load_mask;
        end
        if (conv_ok) begin
            // live flags follow the latest comparison
            st_d.live[idx_lo] = conv.below;
            st_d.live[idx_hi] = conv.above;
            // latched flags only set here, set beats a same-cycle clear
            st_d.latched[idx_lo] = st_d.latched[idx_lo] | conv.below;
            st_d.latched[idx_hi] = st_d.latched[idx_hi] | conv.above;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // serial output
    // ************************************************************
    flag_byte_shifter u_shift (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(rd_take),
        .load_byte(load_byte),
        .busy(sh_busy),
        .done(sh_done),
        .shift_en(sclk_shift),
        .sdo(sdo)
    );

    assign rd_busy = sh_busy;
    assign live_flags = st_q.live;
    assign latched_flags = st_q.latched;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // ch0 low lands in bit 7
    a_live_ch0_low: assert property (conv.valid && conv.chan == 3'h0 |=> st_q.live[7] == $past(conv.below))
        else $error("live ch0 low flag not at bit 7");

    // ch7 high lands in bit 0 of the upper live byte
    a_live_ch7_high: assert property (conv_ok && conv.chan == 3'h7 |=> st_q.live[8] == $past(conv.above))
        else $error("live ch7 high flag not at bit 0 of 14h");

    // ch4 low latches into bit 7 of the upper latched byte
    a_latch_ch4_low: assert property (conv_ok && conv.chan == 3'h4 && conv.below |=> st_q.latched[15])
        else $error("latched ch4 low flag not at bit 7 of 13h");

    // ch3 high latches into bit 0 of the lower latched byte
    a_latch_ch3_high: assert property (conv.valid && conv.chan == 3'h3 && conv.above |=> st_q.latched[0])
        else $error("latched ch3 high flag not at bit 0 of 11h");

    // a cleared condition drops the live flag for two later cycles
    a_live_drop_follow: assert property (conv.valid && conv.chan == 3'h2 && !conv.below
        ##1 !(conv.valid && conv.chan == 3'h2) |-> !st_q.live[3] [*2])
        else $error("live flag held after condition ended");

    // latched flags never fall without a finished read
    a_latch_hold: assert property (!sh_done |=> (st_q.latched & $past(st_q.latched)) == $past(st_q.latched))
        else $error("latched flag lost without read");

    // any fall of a latched bit follows a completed shift
    a_clear_after_shift: assert property (|($past(st_q.latched) & ~st_q.latched) |-> $past(sh_done))
        else $error("latched flag cleared before byte shifted out");

    // flags stay still without conversion or read completion
    a_flags_readonly: assert property (!conv.valid && !sh_done |=> $stable(st_q.live) && $stable(st_q.latched))
        else $error("flag changed without a cause");

    // upper latched bank stays zero on the four-channel part
    a_absent_bank_idle: assert property (four_chan && $past(four_chan) && $past(st_q.latched[15:8]) == FLAGS_RESET
        |-> st_q.latched[15:8] == FLAGS_RESET)
        else $error("absent bank changed");

    // absent register first bit out is one
    a_absent_reads_ones: assert property (rd_take && four_chan && load_bank |=> sdo)
        else $error("absent register did not shift ones");

    // reading 11h shows latched ch0 low first
    a_latch_lo_addr: assert property (rd_take && reg_addr == ADDR_LATCHED_LO |=> sdo == $past(latched_now[7]))
        else $error("11h did not show latched ch0 low");

    // a detected low alarm reads as one in the live byte
    a_flag_polarity: assert property (conv.valid && conv.chan == 3'h1 && conv.below |=> st_q.live[5] == 1'b1)
        else $error("alarm flag not one");

    // ch4 low lands in bit 7 of the upper live byte
    a_live_ch4_low: assert property (conv_ok && conv.chan == 3'h4 |=> st_q.live[15] == $past(conv.below))
        else $error("live ch4 low flag not at bit 7 of 14h");

    // ch7 high latches into bit 0 of the upper latched byte
    a_latch_ch7_high: assert property (conv_ok && conv.chan == 3'h7 && conv.above |=> st_q.latched[8])
        else $error("latched ch7 high flag not at bit 0 of 13h");

    // ch0 low latches into bit 7 of the lower latched byte
    a_latch_ch0_low: assert property (conv.valid && conv.chan == 3'h0 && conv.below |=> st_q.latched[7])
        else $error("latched ch0 low flag not at bit 7 of 11h");

    // reading 12h shows live ch0 low first
    a_live_lo_addr: assert property (rd_take && sel == SEL_LIVE_LO |=> sdo == $past(st_q.live[7]))
        else $error("12h did not show live ch0 low");

    // reading 14h shows live ch4 low first
    a_live_hi_addr: assert property (rd_take && sel == SEL_LIVE_HI && !four_chan |=> sdo == $past(st_q.live[15]))
        else $error("14h did not show live ch4 low");

    // reading 13h shows latched ch4 low first
    a_latch_hi_addr: assert property (rd_take && sel == SEL_LATCHED_HI && !four_chan
        |=> sdo == $past(latched_now[15]))
        else $error("13h did not show latched ch4 low");

    // absent live register first bit out is one
    a_absent_live_ones: assert property (rd_take && four_chan && sel == SEL_LIVE_HI |=> sdo)
        else $error("absent live register did not shift ones");

    // upper live bank stays zero on the four-channel part
    a_absent_live_idle: assert property (four_chan && $past(four_chan) && $past(st_q.live[15:8]) == FLAGS_RESET
        |-> st_q.live[15:8] == FLAGS_RESET)
        else $error("absent live bank changed");

    // a finished lower-bank read clears only the bits it reported
    a_clear_reported_only: assert property (sh_done && !st_q.clr_bank
        |=> ($past(st_q.latched[7:0]) & ~$past(st_q.clr_mask) & ~st_q.latched[7:0]) == NO_CLEAR)
        else $error("unreported latched flag cleared");

    // an unmapped address starts no shift
    a_unmapped_refused: assert property (reg_rd && !sh_busy && sel == SEL_NONE |=> !rd_busy)
        else $error("unmapped address started a shift");

    // a byte stays pending until the host shifts it
    a_busy_until_shift: assert property (sh_busy && !sclk_shift |=> sh_busy)
        else $error("byte ended without a shift");

    // ************************************************************
    // coverage of the main scenarios
    // ************************************************************
    // read of the lower latched byte through to its clear
    c_latched_read_clear: cover property (rd_take && sel == SEL_LATCHED_LO ##[1:40] sh_done);
    // missing bank answered with ones
    c_absent_read: cover property (rd_take && four_chan && sel == SEL_LIVE_HI);
    // new alarm landing in the clear cycle
    c_set_during_clear: cover property (sh_done && conv_ok && (conv.below || conv.above));
    // next read taken right behind the previous byte
    c_back_to_back_read: cover property (sh_done && rd_take);
    // upper channel result dropped on the four-channel part
    c_refused_channel: cover property (four_chan && conv.valid && conv.chan[2]);

endmodule

//--- logic/alarm_flag_pkg.sv
package alarm_flag_pkg;

    // ************************************************************
    // register map and field layout
    // ************************************************************
    localparam logic [6:0] ADDR_LATCHED_LO = 7'h11;
    localparam logic [6:0] ADDR_LIVE_LO = 7'h12;
    localparam logic [6:0] ADDR_LATCHED_HI = 7'h13;
    localparam logic [6:0] ADDR_LIVE_HI = 7'h14;

    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] ABSENT_READ = 8'hFF; // missing bank shifts ones
    localparam logic [7:0] NO_CLEAR = 8'h00;
    localparam logic [2:0] FLAG_TOP = 3'h7; // channel low flag of pair 0
    localparam logic [2:0] SHIFT_LAST = 3'h7; // eighth shift ends a byte
    localparam logic [2:0] CNT_RESET = 3'h0;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_LATCHED_LO,
        SEL_LIVE_LO,
        SEL_LATCHED_HI,
        SEL_LIVE_HI
    } reg_sel_t;

    // one finished conversion with its comparison result
    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic below;
        logic above;
    } conv_t;

    typedef struct packed {
        logic [15:0] live;
        logic [15:0] latched;
        logic clr_bank;
        logic [7:0] clr_mask;
    } flag_state_t;

    typedef struct packed {
        logic busy;
        logic [2:0] cnt;
        logic [7:0] data;
        logic done;
    } shift_state_t;

endpackage

//--- logic/flag_byte_shifter.sv
`timescale 1ns/1ps
module flag_byte_shifter
    import alarm_flag_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // parallel load side
    input wire logic load,
    input wire logic [7:0] load_byte,
    output logic busy,
    output logic done,
    // serial side
    input wire logic shift_en,
    output logic sdo
);

    shift_state_t s_q;
    shift_state_t s_d;

    // ************************************************************
    // msb-first byte shifter
    // ************************************************************

    // load only when idle; done pulses once after the eighth shift
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (!s_q.busy && load) begin
            s_d.busy = 1'b1;
            s_d.cnt = CNT_RESET;
            s_d.data = load_byte;
        end else if (s_q.busy && shift_en) begin
            s_d.data = {s_q.data[6:0], 1'b0};
            s_d.cnt = 3'(s_q.cnt + 3'h1);
            if (s_q.cnt == SHIFT_LAST) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
    assign sdo = s_q.data[7];

endmodule

//--- tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // device serial side
    input wire logic rd_busy,
    input wire logic sdo,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic sclk_shift
);
    // ************************************************************
    // host side of the serial read port
    // ************************************************************
    // idle values at time zero
    initial begin
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        sclk_shift = 1'b0;
    end

    // host reads flags
    // gap idles before each shift, so one task serves fast and slow hosts
    task automatic read_reg(input logic [6:0] a, input int gap, output logic [7:0] d, output bit hung);
        d = 8'h00;
        hung = 1'b0;
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        reg_addr <= ~a; // stale address must not matter
        for (int i = 0; i < 8; i++) begin
            repeat (gap) @(posedge mclk);
            @(negedge mclk);
            if (rd_busy !== 1'b1) hung = 1'b1;
            d = {d[6:0], sdo}; // msb first
            @(posedge mclk);
            sclk_shift <= 1'b1;
            @(posedge mclk);
            sclk_shift <= 1'b0;
        end
        // busy drops on the same edge that takes the eighth shift
        @(negedge mclk);
        if (rd_busy !== 1'b0) hung = 1'b1;
    endtask
endmodule

//--- tb/channel_alarm_flags_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module channel_alarm_flags_tb_top
    import alarm_flag_pkg::*;
;
    typedef struct packed {
        logic [2:0] chan;
        logic below;
        logic above;
        logic [6:0] addr;
        logic [7:0] exp;
    } row_t;

    logic mclk, rst_n, four_chan, reg_rd, rd_busy, sclk_shift, sdo;
    logic [6:0] reg_addr;
    logic [15:0] live_flags, latched_flags;
    logic [7:0] got;
    conv_t conv;
    bit hung;
    int failures, total_checks;
    // each row: one conversion, then one read of the named register
    row_t rows [8] = '{'{3'h0, 1'b1, 1'b0, 7'h12, 8'h80}, '{3'h3, 1'b0, 1'b1, 7'h12, 8'h81},
        '{3'h4, 1'b1, 1'b0, 7'h14, 8'h80}, '{3'h7, 1'b0, 1'b1, 7'h13, 8'h81},
        '{3'h1, 1'b1, 1'b1, 7'h11, 8'hB1}, '{3'h0, 1'b0, 1'b0, 7'h11, 8'h00},
        '{3'h2, 1'b0, 1'b0, 7'h12, 8'h31}, '{3'h5, 1'b1, 1'b0, 7'h13, 8'h20}};

    // ************************************************************
    // device and host
    // ************************************************************
    channel_alarm_flags i_dut (.mclk(mclk), .rst_n(rst_n), .four_chan(four_chan), .conv(conv),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .rd_busy(rd_busy), .sclk_shift(sclk_shift),
        .sdo(sdo), .live_flags(live_flags), .latched_flags(latched_flags));
    host_model i_host (.mclk(mclk), .rst_n(rst_n), .rd_busy(rd_busy), .sdo(sdo),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .sclk_shift(sclk_shift));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic summarize();
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // strap changes only under reset
    task automatic do_reset(input logic fc);
        @(posedge mclk);
        rst_n <= 1'b0;
        four_chan <= fc;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        `CHK({live_flags, latched_flags, rd_busy, sdo}, 34'h0)
    endtask

    task automatic send_conv(input logic [2:0] ch, input logic lo, input logic hi);
        @(posedge mclk);
        conv <= '{1'b1, ch, lo, hi};
        @(posedge mclk);
        conv <= '0;
    endtask

    // a read that never finishes counts as a mismatch and ends the run
    task automatic rd(input logic [6:0] a, input int g, output logic [7:0] d);
        bit h;
        i_host.read_reg(a, g, d, h);
        `CHK(h, 1'b0)
        if (h) summarize();
    endtask

    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        rst_n = 1'b0;
        four_chan = 1'b0;
        conv = '0;
        failures = 0;
        total_checks = 0;
        do_reset(1'b0);
        foreach (rows[i]) begin
            send_conv(rows[i].chan, rows[i].below, rows[i].above);
            rd(rows[i].addr, (i % 2) * 3, got);
            `CHK(got, rows[i].exp)
        end
        send_conv(3'h2, 1'b0, 1'b1);
        send_conv(3'h2, 1'b0, 1'b0);
        @(negedge mclk);
        `CHK(live_flags[3:2], 2'h0)
        rd(7'h11, 0, got);
        `CHK(got, 8'h04)
        // a set during the read survives its clear
        send_conv(3'h0, 1'b1, 1'b0);
        fork
            rd(7'h11, 0, got);
            begin
                repeat (6) @(posedge mclk);
                send_conv(3'h3, 1'b1, 1'b0);
            end
        join
        repeat (2) @(negedge mclk);
        `CHK(got, 8'h80)
        `CHK(latched_flags[7:0], 8'h02)
        // unmapped address starts no shift
        i_host.read_reg(7'h15, 0, got, hung);
        `CHK(hung, 1'b1)
        do_reset(1'b1);
        send_conv(3'h5, 1'b1, 1'b1);
        send_conv(3'h1, 1'b0, 1'b1);
        rd(7'h13, 0, got);
        `CHK(got, 8'hFF)
        rd(7'h14, 2, got);
        `CHK(got, 8'hFF)
        `CHK({live_flags[15:8], latched_flags[15:8]}, 16'h0)
        rd(7'h11, 0, got);
        `CHK(got, 8'h10)
        summarize();
    end
endmodule
